// ### rtl/clk_timer_pkg.sv
package clk_timer_pkg;

    // register indices; byte address is four times the index
    localparam logic [29:0] IDX_PRIORITY = 30'h0000FF20;
    localparam logic [29:0] IDX_ENABLE   = 30'h0000FF22;
    localparam logic [29:0] IDX_FLAGS    = 30'h0000FF24;
    localparam logic [29:0] IDX_CONTROL  = 30'h0000FF40;
    localparam logic [29:0] IDX_COUNT    = 30'h0000FF41;

    // reset values
    localparam logic [7:0]  PRIORITY_RST = 8'h00;
    localparam logic [6:0]  ENABLE_RST   = 7'h00;
    localparam logic [3:0]  FLAGS_RST    = 4'h0;
    localparam logic [7:0]  COUNT_RST    = 8'h00;
    localparam logic [2:0]  FSEL_RST     = 3'h0;

    // control register fields
    localparam int RUN_BIT     = 0;
    localparam int CLEAR_BIT   = 1;
    localparam int WDOG_BIT    = 2;
    localparam int DIVIDED_FREQ_PIN_EN_BIT = 3;
    localparam int FSEL_LSB    = 4;
    localparam int FSEL_MSB    = 6;
    localparam int FSEL_OSC    = 2;    // select bit that picks the high-speed oscillator

    // enable / flag layout (clock timer part)
    localparam int EV_1HZ    = 0;
    localparam int EV_2HZ    = 1;
    localparam int EV_8HZ    = 2;
    localparam int EV_MINUTE = 3;
    localparam int EV_COUNT  = 4;
    localparam int ENABLE_W  = 7;      // clock timer plus stopwatch enables

    // counter stage positions
    localparam int STAGE_1HZ = 7;
    localparam int STAGE_2HZ = 6;
    localparam int STAGE_8HZ = 4;

    // priority register: timer field sits at the bottom
    localparam int TIMER_PRIO_LSB = 0;
    localparam int TIMER_PRIO_MSB = 1;

    // one-second events per minute event
    localparam logic [5:0] SECONDS_PER_MINUTE = 6'h3C;
    localparam logic [5:0] SECONDS_LAST       = 6'h3B;

    // AHB-Lite encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic       HRESP_OKAY = 1'b0;

    typedef enum logic [2:0]
    {
        SEL_NONE     = 3'b000,
        SEL_PRIORITY = 3'b001,
        SEL_ENABLE   = 3'b010,
        SEL_FLAGS    = 3'b011,
        SEL_CONTROL  = 3'b100,
        SEL_COUNT    = 3'b101
    } reg_sel_t;

endpackage

// ### rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
    import clk_timer_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    typedef struct packed
    {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;

    sync_state_t s_r;
    sync_state_t s_nxt;

    // first stage feeds only the second stage
    always_comb
    begin
        s_nxt.meta   = d_i;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign q_o = s_r.stable;

endmodule

// ### rtl/freq_out_gen.sv
`timescale 1ns/1ps
module freq_out_gen
    import clk_timer_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       low_speed_osc_i,
    input  wire logic       high_speed_osc_i,
    input  wire logic [2:0] freq_select_i,
    input  wire logic       freq_pin_enable_i,
    output logic            divided_freq_pin_o
);

    typedef struct packed
    {
        logic       lo_prev;
        logic       hi_prev;
        logic [2:0] lo_div;
        logic [2:0] hi_div;
        logic       pin;
    } freq_state_t;

    freq_state_t s_r;
    freq_state_t s_nxt;
    logic [3:0]  lo_taps;
    logic [3:0]  hi_taps;

    // ripple dividers count rising edges of the already synchronised oscillators;
    // the fast oscillator is only honest well below half the system clock
    always_comb
    begin
        s_nxt         = s_r;
        s_nxt.lo_prev = low_speed_osc_i;
        s_nxt.hi_prev = high_speed_osc_i;
        if (low_speed_osc_i && !s_r.lo_prev)
            s_nxt.lo_div = s_r.lo_div + 3'h1;
        if (high_speed_osc_i && !s_r.hi_prev)
            s_nxt.hi_div = s_r.hi_div + 3'h1;
        lo_taps = {s_r.lo_div, low_speed_osc_i};
        hi_taps = {s_r.hi_div, high_speed_osc_i};
        // pin idles low while disabled
        if (!freq_pin_enable_i)
            s_nxt.pin = 1'b0;
        else if (freq_select_i[FSEL_OSC])
            s_nxt.pin = hi_taps[freq_select_i[1:0]];
        else
            s_nxt.pin = lo_taps[freq_select_i[1:0]];
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign divided_freq_pin_o = s_r.pin;

    pin_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !freq_pin_enable_i |=> !divided_freq_pin_o)
        else $error("frequency pin high while disabled");

endmodule

// ### rtl/clk_timer.sv
// Contract
// - control D0 run-stop bit, reset zero
// - D6..D4 select oscillator divide, D3 enables pin
// - read-only count byte, D7 is 1 Hz
// - D0 is 128 Hz stage, binary chain
// - timer priority D1..D0, 00 masks
// - other priority fields plain read/write storage
// - 1 Hz interrupt enable bit
// - 2 Hz interrupt enable bit
// - 8 Hz interrupt enable bit
// - minute interrupt enable bit
// - stopwatch enable bits plain storage
// - 1 Hz flag sticky, write one clears
// - 2 Hz flag sticky, write one clears
// - 8 Hz flag sticky, write one clears
// - minute flag sticky, write one clears
// - stop only after one more count
`timescale 1ns/1ps
module clk_timer
    import clk_timer_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic      [31:0] hrdata_o,
    // pins from the oscillator block
    input  wire logic        tick_256hz_i,
    input  wire logic        low_speed_osc_i,
    input  wire logic        high_speed_osc_i,
    // outputs
    output logic             divided_freq_pin_o,
    output logic             watchdog_clear_strobe_o,
    output logic             timer_irq_o,
    output logic      [1:0]  timer_irq_level_o
);

    typedef struct packed
    {
        // control register
        logic       count_run_stop;
        logic       freq_pin_enable;
        logic [2:0] freq_select;
        // counter
        logic [7:0] count;
        logic       counting;
        logic [5:0] seconds;
        logic       tick_prev;
        // interrupt registers
        logic [7:0] priority_reg;
        logic [6:0] enable_reg;
        logic [3:0] flags;
        // strobes
        logic       wdog_pulse;
        // bus data phase
        logic       dp_write;
        reg_sel_t   dp_sel;
        logic [31:0] rdata;
    } timer_state_t;

    timer_state_t s_r;
    timer_state_t s_nxt;

    logic [2:0] pins_sync;
    logic       tick_sync;
    logic       lo_sync;
    logic       hi_sync;

    logic       addr_valid;
    reg_sel_t   addr_sel;
    logic       wr_ctrl;
    logic       wr_prio;
    logic       wr_enable;
    logic       wr_flags;
    logic [7:0] wbyte;
    logic [3:0] w1c;
    logic       tick_rise;
    logic       advance;
    logic       clear_cmd;
    logic [7:0] count_inc;
    logic [3:0] events;
    logic       pending_any;

    // address decode: one aligned word per register index
    function automatic reg_sel_t decode(input logic [31:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        case (addr[31:2])
            IDX_PRIORITY: sel = SEL_PRIORITY;
            IDX_ENABLE:   sel = SEL_ENABLE;
            IDX_FLAGS:    sel = SEL_FLAGS;
            IDX_CONTROL:  sel = SEL_CONTROL;
            IDX_COUNT:    sel = SEL_COUNT;
            default:      sel = SEL_NONE;
        endcase
        return sel;
    endfunction

    // a stage completes a period when it falls from one to zero
    function automatic logic stage_fell(input logic [7:0] before_v,
                                        input logic [7:0] after_v,
                                        input int         pos);
        return before_v[pos] && !after_v[pos];
    endfunction

    // register read mux; strobe bits and unused bits read as zero
    function automatic logic [31:0] read_word(input timer_state_t st, input reg_sel_t sel);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (sel)
            SEL_PRIORITY: w[7:0] = st.priority_reg;
            SEL_ENABLE:   w[6:0] = st.enable_reg;
            SEL_FLAGS:    w[3:0] = st.flags;
            SEL_CONTROL:
            begin
                w[RUN_BIT]           = st.count_run_stop;
                w[DIVIDED_FREQ_PIN_EN_BIT]       = st.freq_pin_enable;
                w[FSEL_MSB:FSEL_LSB] = st.freq_select;
            end
            SEL_COUNT:    w[7:0] = st.count;
            default:      w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // the 256 Hz tick and both oscillators come from outside this clock
    pin_sync #(
        .W (3)
    ) u_pin_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({high_speed_osc_i, low_speed_osc_i, tick_256hz_i}),
        .q_o   (pins_sync)
    );

    assign tick_sync = pins_sync[0];
    assign lo_sync   = pins_sync[1];
    assign hi_sync   = pins_sync[2];

    freq_out_gen u_freq_out_gen (
        .clk_i              (clk_i),
        .rst_i              (rst_i),
        .low_speed_osc_i    (lo_sync),
        .high_speed_osc_i   (hi_sync),
        .freq_select_i      (s_r.freq_select),
        .freq_pin_enable_i  (s_r.freq_pin_enable),
        .divided_freq_pin_o (divided_freq_pin_o)
    );

    // next-state logic: bus writes land first, then counter and flags
    always_comb
    begin
        s_nxt = s_r;

        // address phase; only whole-word transfers are honoured
        addr_valid = hsel_i && htrans_i[1] && hready_i && (hsize_i == HSIZE_WORD);
        addr_sel   = addr_valid ? decode(haddr_i) : SEL_NONE;
        s_nxt.dp_write = addr_valid && hwrite_i;
        s_nxt.dp_sel   = addr_sel;

        // data phase write strobes
        wbyte     = hwdata_i[7:0];
        wr_ctrl   = s_r.dp_write && (s_r.dp_sel == SEL_CONTROL);
        wr_prio   = s_r.dp_write && (s_r.dp_sel == SEL_PRIORITY);
        wr_enable = s_r.dp_write && (s_r.dp_sel == SEL_ENABLE);
        wr_flags  = s_r.dp_write && (s_r.dp_sel == SEL_FLAGS);

        // control register fields
        if (wr_ctrl)
        begin
            s_nxt.count_run_stop  = wbyte[RUN_BIT];
            s_nxt.freq_pin_enable = wbyte[DIVIDED_FREQ_PIN_EN_BIT];
            s_nxt.freq_select     = wbyte[FSEL_MSB:FSEL_LSB];
        end
        clear_cmd        = wr_ctrl && wbyte[CLEAR_BIT];
        s_nxt.wdog_pulse = wr_ctrl && wbyte[WDOG_BIT];

        // all four priority fields are stored whole
        if (wr_prio)
            s_nxt.priority_reg = wbyte;
        // timer and stopwatch enables
        if (wr_enable)
            s_nxt.enable_reg = wbyte[ENABLE_W-1:0];

        // counter advances on a 256 Hz edge while running, and once more after a stop
        s_nxt.tick_prev = tick_sync;
        tick_rise = tick_sync && !s_r.tick_prev;
        advance   = tick_rise && (s_r.count_run_stop || s_r.counting);
        count_inc = s_r.count + 8'h01;
        events    = '0;

        if (clear_cmd)
        begin
            // clear wins over a coincident tick; no events from a clear
            s_nxt.count   = COUNT_RST;
            s_nxt.seconds = 6'h00;
        end
        else if (advance)
        begin
            s_nxt.count      = count_inc;
            events[EV_1HZ]   = stage_fell(s_r.count, count_inc, STAGE_1HZ);
            events[EV_2HZ]   = stage_fell(s_r.count, count_inc, STAGE_2HZ);
            events[EV_8HZ]   = stage_fell(s_r.count, count_inc, STAGE_8HZ);
            if (events[EV_1HZ])
            begin
                if (s_r.seconds == SECONDS_LAST)
                begin
                    s_nxt.seconds     = 6'h00;
                    events[EV_MINUTE] = 1'b1;
                end
                else
                begin
                    s_nxt.seconds = s_r.seconds + 6'h01;
                end
            end
        end

        // a stop request lets exactly one more count through
        if (s_nxt.count_run_stop)
            s_nxt.counting = 1'b1;
        else if (advance)
            s_nxt.counting = 1'b0;

        // sticky flags: an event in the clearing cycle survives
        w1c         = wr_flags ? wbyte[EV_COUNT-1:0] : 4'h0;
        s_nxt.flags = (s_r.flags & ~w1c) | events;

        // read data is taken from the post-write state so a read right after
        // a write sees the new value
        s_nxt.rdata = (addr_valid && !hwrite_i) ? read_word(s_nxt, addr_sel) : 32'h0000_0000;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_r                 <= '0;
            s_r.priority_reg    <= PRIORITY_RST;
            s_r.enable_reg      <= ENABLE_RST;
            s_r.flags           <= FLAGS_RST;
            s_r.count           <= COUNT_RST;
            s_r.freq_select     <= FSEL_RST;
            s_r.dp_sel          <= SEL_NONE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // zero-wait slave, always OKAY
    assign hreadyout_o = 1'b1;
    assign hresp_o     = HRESP_OKAY;
    assign hrdata_o    = s_r.rdata;

    assign watchdog_clear_strobe_o = s_r.wdog_pulse;

    // level interrupt: unmasked pending flag and a non-zero priority
    assign pending_any = |(s_r.flags & s_r.enable_reg[EV_COUNT-1:0]);
    assign timer_irq_o = pending_any &&
                         (s_r.priority_reg[TIMER_PRIO_MSB:TIMER_PRIO_LSB] != 2'b00);
    assign timer_irq_level_o = timer_irq_o ?
                               s_r.priority_reg[TIMER_PRIO_MSB:TIMER_PRIO_LSB] : 2'b00;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    run_bit_write_a: assert property (
        (wr_ctrl && !wbyte[RUN_BIT]) |=> !s_r.count_run_stop)
        else $error("run bit not cleared by write");

    count_frozen_a: assert property (
        (!s_r.counting && !s_r.count_run_stop && !clear_cmd) |=> $stable(s_r.count))
        else $error("counter moved while stopped");

    last_count_a: assert property (
        (s_r.counting && !s_r.count_run_stop && tick_rise && !clear_cmd && !wr_ctrl)
        |=> (s_r.count == $past(s_r.count) + 8'h01) && !s_r.counting)
        else $error("final count after stop missing");

    clear_count_a: assert property (
        clear_cmd |=> (s_r.count == COUNT_RST) && (s_r.seconds == 6'h00))
        else $error("counter clear failed");

    wdog_cause_a: assert property (
        watchdog_clear_strobe_o |-> $past(wr_ctrl) && $past(wbyte[WDOG_BIT]))
        else $error("watchdog strobe without a write");

    flag_sticky_a: assert property (
        (s_r.flags[EV_2HZ] && !w1c[EV_2HZ]) |=> s_r.flags[EV_2HZ])
        else $error("2 Hz flag lost without clear");

    event_sets_a: assert property (
        events[EV_8HZ] |=> s_r.flags[EV_8HZ])
        else $error("8 Hz event did not set flag");

    minute_event_a: assert property (
        events[EV_MINUTE] |-> events[EV_1HZ] && (s_r.seconds == SECONDS_LAST))
        else $error("minute event at wrong second");

    irq_raise_a: assert property (
        (events[EV_1HZ] && s_r.enable_reg[EV_1HZ] && !wr_enable && !wr_prio
         && (s_r.priority_reg[TIMER_PRIO_MSB:TIMER_PRIO_LSB] != 2'b00))
        |=> timer_irq_o && (timer_irq_level_o == $past(s_r.priority_reg[1:0])))
        else $error("enabled 1 Hz event raised no interrupt");

    strobe_reads_zero_a: assert property (
        (addr_valid && !hwrite_i && addr_sel == SEL_CONTROL)
        |=> (hrdata_o[CLEAR_BIT] == 1'b0) && (hrdata_o[WDOG_BIT] == 1'b0))
        else $error("strobe bit read back non-zero");

endmodule

// ### testbench/osc_model.sv
`timescale 1ns/1ps
module osc_model
(
    input  wire logic        clk_i,
    input  wire logic        tick_en_i,
    output logic             tick_256hz_o,
    output logic             low_speed_osc_o,
    output logic             high_speed_osc_o,
    output logic      [15:0] tick_edges_o
);
    logic       ph_r   = 1'b0;
    logic [2:0] low_r  = 3'h0;
    logic [1:0] high_r = 2'h0;

    initial
    begin
        tick_256hz_o     = 1'b0;
        low_speed_osc_o  = 1'b0;
        high_speed_osc_o = 1'b0;
        tick_edges_o     = 16'h0000;
    end

    // tick rests low between bursts, so no stray count reaches the timer
    always @(posedge clk_i)
    begin
        if (!tick_en_i)
        begin
            tick_256hz_o <= 1'b0;
            ph_r         <= 1'b0;
        end
        else
        begin
            ph_r <= ~ph_r;
            if (ph_r)
            begin
                tick_256hz_o <= ~tick_256hz_o;
                if (!tick_256hz_o)
                    tick_edges_o <= tick_edges_o + 16'h0001;
            end
        end
    end

    // oscillators: low toggles every 8 clocks, high every 3
    always @(posedge clk_i)
    begin
        low_r  <= low_r + 3'h1;
        high_r <= (high_r == 2'h2) ? 2'h0 : high_r + 2'h1;
        if (low_r == 3'h7)
            low_speed_osc_o <= ~low_speed_osc_o;
        if (high_r == 2'h2)
            high_speed_osc_o <= ~high_speed_osc_o;
    end
endmodule

// ### testbench/tb_clk_timer.sv
`timescale 1ns/1ps
module tb_clk_timer
    import clk_timer_pkg::*;
;
    logic        clk_i   = 1'b0;
    logic        rst_i   = 1'b1;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [31:0] hwdata  = 32'h0;
    logic        tick_en = 1'b0;
    logic [2:0]  hsize   = HSIZE_WORD;
    logic        hready, hresp, tick, low_osc, high_osc, fpin, wd_strobe, irq;
    logic [31:0] hrdata, rd_q;
    logic [1:0]  irq_lvl;
    logic [15:0] edges;
    logic        rdy_q, pin_q, rs_q;
    int          fails = 0, checks_done = 0, cycles = 0, wd_cnt = 0, pin_cnt = 0;

    always #5 clk_i = ~clk_i;

    // answers are captured by the edge itself, so reads never race the design
    always @(posedge clk_i)
    begin
        rd_q   <= hrdata;
        rdy_q  <= hready;
        rs_q   <= hresp;
        pin_q  <= fpin;
        cycles <= cycles + 1;
        if (pin_q !== fpin)
            pin_cnt <= pin_cnt + 1;
        if (wd_strobe === 1'b1)
            wd_cnt <= wd_cnt + 1;
        if (cycles == 90000)
        begin
            fails++;
            test_done();
        end
    end

    clk_timer clk_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
        .tick_256hz_i(tick), .low_speed_osc_i(low_osc), .high_speed_osc_i(high_osc),
        .divided_freq_pin_o(fpin), .watchdog_clear_strobe_o(wd_strobe),
        .timer_irq_o(irq), .timer_irq_level_o(irq_lvl));

    osc_model osc_model_inst (.clk_i(clk_i), .tick_en_i(tick_en), .tick_256hz_o(tick),
        .low_speed_osc_o(low_osc), .high_speed_osc_o(high_osc), .tick_edges_o(edges));

    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic edge_wait();
        @(posedge clk_i);
        #1;
    endtask

    // one single word transfer; address phase, then data phase
    task automatic bus(input logic [29:0] idx, input logic wr, input logic [7:0] wd,
                       output logic [7:0] rd);
        hsel   <= 1'b1;
        haddr  <= {idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        edge_wait();
        while (rdy_q !== 1'b1) edge_wait();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        edge_wait();
        while (rdy_q !== 1'b1) edge_wait();
        rd = rd_q[7:0];
    endtask

    task automatic wr(input logic [29:0] idx, input logic [7:0] d);
        logic [7:0] v;
        bus(idx, 1'b1, d, v);
    endtask

    task automatic rd_chk(input logic [29:0] idx, input logic [7:0] exp);
        logic [7:0] v;
        bus(idx, 1'b0, 8'h00, v);
        chk(v, exp);
        chk({7'h0, rs_q}, {7'h0, HRESP_OKAY});
    endtask

    // irq pin and level packed as {irq, level}
    task automatic irq_chk(input logic [7:0] exp);
        chk({5'h0, irq, irq_lvl}, exp);
    endtask

    task automatic ticks(input int n);
        int target;
        target = edges + n;
        tick_en <= 1'b1;
        while (edges < target) edge_wait();
        tick_en <= 1'b0;
        repeat (8) edge_wait();
    endtask

    task automatic t_reset_values();
        rd_chk(IDX_PRIORITY, 8'h00);
        rd_chk(IDX_ENABLE, 8'h00);
        rd_chk(IDX_FLAGS, 8'h00);
        rd_chk(IDX_CONTROL, 8'h00);
        rd_chk(IDX_COUNT, 8'h00);
        rd_chk(IDX_PRIORITY + 30'h1, 8'h00);
        irq_chk(8'h00);
    endtask

    task automatic t_reg_access();
        int w0;
        wr(IDX_PRIORITY, 8'hFF);
        rd_chk(IDX_PRIORITY, 8'hFF);
        wr(IDX_PRIORITY, 8'h00);
        // a byte-sized write must be ignored by the slave
        hsize <= 3'h0;
        wr(IDX_PRIORITY, 8'h55);
        hsize <= HSIZE_WORD;
        rd_chk(IDX_PRIORITY, 8'h00);
        wr(IDX_ENABLE, 8'hFF);
        rd_chk(IDX_ENABLE, 8'h7F);
        wr(IDX_ENABLE, 8'h00);
        w0 = wd_cnt;
        wr(IDX_CONTROL, 8'hFF);
        rd_chk(IDX_CONTROL, 8'h79);
        wr(IDX_CONTROL, 8'h00);
        repeat (2) edge_wait();
        chk(8'(wd_cnt - w0), 8'h01);
    endtask

    task automatic t_counting();
        wr(IDX_CONTROL, 8'h02);
        wr(IDX_CONTROL, 8'h01);
        ticks(5);
        rd_chk(IDX_COUNT, 8'h05);
        rd_chk(IDX_FLAGS, 8'h00);
        wr(IDX_COUNT, 8'hAA);
        rd_chk(IDX_COUNT, 8'h05);
        ticks(251);
        rd_chk(IDX_COUNT, 8'h00);
        rd_chk(IDX_FLAGS, 8'h07);
    endtask

    // flags 1, 2 and 8 Hz are pending on entry
    task automatic t_irq();
        wr(IDX_ENABLE, 8'h01);
        irq_chk(8'h00);
        wr(IDX_PRIORITY, 8'h02);
        irq_chk(8'h06);
        wr(IDX_FLAGS, 8'h06);
        rd_chk(IDX_FLAGS, 8'h01);
        irq_chk(8'h06);
        wr(IDX_FLAGS, 8'h00);
        rd_chk(IDX_FLAGS, 8'h01);
        wr(IDX_FLAGS, 8'h01);
        rd_chk(IDX_FLAGS, 8'h00);
        irq_chk(8'h00);
        wr(IDX_ENABLE, 8'h04);
        wr(IDX_PRIORITY, 8'h03);
        ticks(32);
        irq_chk(8'h07);
        wr(IDX_FLAGS, 8'h0F);
        wr(IDX_ENABLE, 8'h00);
    endtask

    // counter stands at 0x20 on entry
    task automatic t_stop();
        wr(IDX_CONTROL, 8'h00);
        ticks(3);
        rd_chk(IDX_COUNT, 8'h21);
        ticks(2);
        rd_chk(IDX_COUNT, 8'h21);
    endtask

    task automatic t_minute();
        wr(IDX_FLAGS, 8'h0F);
        wr(IDX_CONTROL, 8'h03);
        ticks(15359);
        rd_chk(IDX_FLAGS, 8'h07);
        wr(IDX_FLAGS, 8'h07);
        wr(IDX_ENABLE, 8'h01);
        irq_chk(8'h00);
        ticks(1);
        rd_chk(IDX_FLAGS, 8'h0F);
        irq_chk(8'h07);
    endtask

    // pin edges over a window against the selected source and divider
    task automatic t_freq();
        int n0, n, exp;
        logic [7:0] cv;
        for (int c = 0; c < 9; c++)
        begin
            cv = (c < 8) ? {1'b0, 3'(c), 4'h8} : 8'h70;
            wr(IDX_CONTROL, cv);
            rd_chk(IDX_CONTROL, cv);
            repeat (16) edge_wait();
            n0 = pin_cnt;
            repeat (480) edge_wait();
            n = pin_cnt - n0;
            exp = (c == 8) ? 0 : (((c < 4) ? 60 : 160) >> (c % 4));
            checks_done++;
            if (n < exp - 2 || n > exp + 2)
            begin
                fails++;
                $display("wrong value at %0t: pin edges %0d for code %0d", $time, n, c);
            end
        end
    endtask

    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        edge_wait();
        t_reset_values();
        t_reg_access();
        t_counting();
        t_irq();
        t_stop();
        t_minute();
        t_freq();
        test_done();
    end
endmodule
